// [hw/imk_core.sv]
// immobilizer key registration, arming and indicator control
`timescale 1ns/1ns
`include "imk_map.svh"
// Behaviour
// - first switch-on after unit replacement registers master key, lamp one second
// - switch-off arms; after 30 s the lamp flashes the standby pattern
// - standby flashing stops after 24 hours, system stays armed
// - switch-on with unregistered key flashes fault code 52
// - entry only in standby: master on, off, removed within 5 s
// - key switched on within 5 s of master removal enters registration
// - entering registration erases all stored standard key codes
// - registration mode drives a rapid flash distinct from standby
// - second key accepted only if inserted within 5 s of first key switch-off
// - no second key in 5 s ends registration and rapid flash
// - second key on stores its code, lamp off, registration ends
// - re-registering with the remaining key voids a lost key
// - one master and two standard slots; only registered keys enable start
// - registered standard keys start without the master key present
// - a fault reports its code and flashes the same code on the lamp
module imk_core #(
   parameter int CODE_W = `IMK_CODE_W,
   parameter int SEC_CYCLES = `IMK_CLK_HZ,
   parameter int STBY_MAX_S = `IMK_STBY_MAX_H * `IMK_SEC_PER_H
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SW_ON,
   input wire logic KEY_IN,
   input wire logic [CODE_W-1:0] KEY_CODE,
   output logic LAMP,
   output logic ENGINE_EN,
   output logic ARMED,
   output logic STANDBY,
   output logic REG_MODE,
   output logic FAULT_VALID,
   output logic [7:0] FAULT_CODE
);
   initial begin
      if (CODE_W < 1)
         $error("imk_core: CODE_W must be positive");
      if (STBY_MAX_S < 1 || STBY_MAX_S >= 131072)
         $error("imk_core: STBY_MAX_S out of range");
   end

   localparam logic [16:0] LIM_LAMP = 17'(`IMK_REG_LAMP_S - 1);
   localparam logic [16:0] LIM_DLY = 17'(`IMK_STBY_DLY_S - 1);
   localparam logic [16:0] LIM_WIN = 17'(`IMK_SEQ_WIN_S - 1);
   localparam logic [16:0] LIM_MAX = 17'(STBY_MAX_S - 1);
   localparam logic [7:0] F_TENS = 8'(`IMK_FAULT_UNREG / 10);
   localparam logic [7:0] F_UNITS = 8'(`IMK_FAULT_UNREG % 10);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the key code is only used while the key sits still
   logic sw_m, sw_s, sw_d, key_m, key_s, key_d;
   logic [CODE_W-1:0] code_m, code_s;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sw_m <= 1'b0;
         sw_s <= 1'b0;
         key_m <= 1'b0;
         key_s <= 1'b0;
         code_m <= '0;
         code_s <= '0;
      end else begin
         sw_m <= SW_ON;
         sw_s <= sw_m;
         key_m <= KEY_IN;
         key_s <= key_m;
         code_m <= KEY_CODE;
         code_s <= code_m;
      end
   end

   // delayed copies for edge detection
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sw_d <= 1'b0;
         key_d <= 1'b0;
      end else begin
         sw_d <= sw_s;
         key_d <= key_s;
      end
   end

   logic on_ev, off_ev, key_ins, key_rem;
   assign on_ev = sw_s && !sw_d;
   assign off_ev = !sw_s && sw_d;
   assign key_ins = key_s && !key_d;
   assign key_rem = !key_s && key_d;

   ////////////////////////////////////////////////////////////////////////////
   // timebase
   imk_tick_if tk ();
   imk_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
      .clk(CLK),
      .arst_n(ARST_N),
      .tk(tk)
   );

   imk_pkg::imk_state_t state, next_state;
   logic [16:0] sec_cnt;
   logic sec_due;

   // every state change restarts the second counter and the prescaler
   assign tk.restart = (next_state != state);

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         sec_cnt <= 17'h0;
      else if (tk.restart)
         sec_cnt <= 17'h0;
      else if (tk.tick_sec && sec_cnt != 17'h1ffff)
         sec_cnt <= sec_cnt + 17'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // key code memory: one master slot, STD standard slots
   localparam int STD = `IMK_STD_KEYS;
   logic [CODE_W-1:0] master_code;
   logic master_ok;
   logic [CODE_W-1:0] std_code [STD];
   logic [STD-1:0] std_ok;
   logic [STD-1:0] std_hit;
   logic is_master, is_std;

   genvar g;
   generate
      for (g = 0; g < STD; g++) begin : g_hit
         assign std_hit[g] = std_ok[g] && (std_code[g] == code_s);
      end
   endgenerate
   assign is_master = master_ok && (master_code == code_s);
   assign is_std = |std_hit;

   // decision taken at switch-on in the off states ST_ARMED, ST_STBY, ST_QUIET, ST_MOFF and ST_MWAIT
   function automatic imk_pkg::imk_state_t on_target(imk_pkg::imk_state_t s);
      imk_pkg::imk_state_t r;
      if (!master_ok)
         r = imk_pkg::ST_MREG;
      else if (is_master)
         r = (s == imk_pkg::ST_STBY) ? imk_pkg::ST_MON : imk_pkg::ST_RUN;
      else if (s == imk_pkg::ST_MWAIT)
         r = imk_pkg::ST_REG1;
      else if (is_std)
         r = imk_pkg::ST_RUN;
      else
         r = imk_pkg::ST_FAULT;
      return r;
   endfunction : on_target

   ////////////////////////////////////////////////////////////////////////////
   // state sequence
   always_comb begin
      sec_due = tk.tick_sec;
      next_state = state;
      unique case (state)
         imk_pkg::ST_ARMED: begin
            if (on_ev)
               next_state = on_target(state);
            else if (sec_due && sec_cnt == LIM_DLY)
               next_state = imk_pkg::ST_STBY;
         end
         imk_pkg::ST_STBY: begin
            if (on_ev)
               next_state = on_target(state);
            else if (sec_due && sec_cnt == LIM_MAX)
               next_state = imk_pkg::ST_QUIET;
         end
         imk_pkg::ST_QUIET: begin
            if (on_ev)
               next_state = on_target(state);
         end
         imk_pkg::ST_MREG: begin
            if (off_ev)
               next_state = imk_pkg::ST_ARMED;
            else if (sec_due && sec_cnt == LIM_LAMP)
               next_state = imk_pkg::ST_RUN;
         end
         imk_pkg::ST_RUN, imk_pkg::ST_FAULT, imk_pkg::ST_REG1: begin
            if (off_ev)
               next_state = (state == imk_pkg::ST_REG1) ? imk_pkg::ST_REG1OFF : imk_pkg::ST_ARMED;
         end
         imk_pkg::ST_MON: begin
            if (off_ev)
               next_state = imk_pkg::ST_MOFF;
         end
         imk_pkg::ST_MOFF: begin
            if (on_ev)
               next_state = on_target(state);
            else if (key_rem)
               next_state = imk_pkg::ST_MWAIT;
            else if (sec_due && sec_cnt == LIM_WIN)
               next_state = imk_pkg::ST_ARMED;
         end
         imk_pkg::ST_MWAIT: begin
            if (on_ev)
               next_state = on_target(state);
            else if (sec_due && sec_cnt == LIM_WIN)
               next_state = imk_pkg::ST_ARMED;
         end
         imk_pkg::ST_REG1OFF: begin
            if (key_ins)
               next_state = imk_pkg::ST_REG2W;
            else if (sec_due && sec_cnt == LIM_WIN)
               next_state = imk_pkg::ST_ARMED;
         end
         imk_pkg::ST_REG2W: begin
            if (on_ev)
               next_state = imk_pkg::ST_RUN;
            else if (key_rem)
               next_state = imk_pkg::ST_ARMED;
         end
         default: next_state = imk_pkg::ST_ARMED;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         state <= imk_pkg::ST_ARMED;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // code storage; reset stands for a replaced unit with empty memory
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         master_code <= '0;
         master_ok <= 1'b0;
      end else if (next_state == imk_pkg::ST_MREG && state != imk_pkg::ST_MREG) begin
         master_code <= code_s;
         master_ok <= 1'b1;
      end
   end

   generate
      for (g = 0; g < STD; g++) begin : g_slot
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               std_code[g] <= '0;
               std_ok[g] <= 1'b0;
            end else if (state != imk_pkg::ST_REG1 && next_state == imk_pkg::ST_REG1) begin
               // erase all, first key into slot 0; voids any lost key
               std_ok[g] <= (g == 0);
               if (g == 0)
                  std_code[g] <= code_s;
            end else if (g == 1 && state == imk_pkg::ST_REG2W && on_ev && !std_hit[0]) begin
               std_code[g] <= code_s;
               std_ok[g] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // flash phase and fault-code blink sequencer
   logic [3:0] ph;
   imk_pkg::imk_seq_t seq;
   logic [7:0] seq_n;
   logic [4:0] seq_t;
   logic code_lamp;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         ph <= 4'h0;
      else if (tk.restart)
         ph <= 4'h0;
      else if (tk.tick_fast)
         ph <= ph + 4'h1;
   end

   // tens as long blinks, units as short ones, then a dark gap
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         seq <= imk_pkg::SQ_TENS;
         seq_n <= 8'h0;
         seq_t <= 5'h0;
      end else if (state != imk_pkg::ST_FAULT) begin
         seq <= imk_pkg::SQ_TENS;
         seq_n <= 8'h0;
         seq_t <= 5'h0;
      end else if (tk.tick_fast) begin
         seq_t <= seq_t + 5'h1;
         unique case (seq)
            imk_pkg::SQ_TENS: if (seq_t == 5'(`IMK_LONG_PER - 1)) begin
               seq_t <= 5'h0;
               seq_n <= seq_n + 8'h1;
               if (seq_n == F_TENS - 8'h1) begin
                  seq <= imk_pkg::SQ_UNITS;
                  seq_n <= 8'h0;
               end
            end
            imk_pkg::SQ_UNITS: if (seq_t == 5'(`IMK_SHORT_PER - 1)) begin
               seq_t <= 5'h0;
               seq_n <= seq_n + 8'h1;
               if (seq_n == F_UNITS - 8'h1) begin
                  seq <= imk_pkg::SQ_GAP;
                  seq_n <= 8'h0;
               end
            end
            imk_pkg::SQ_GAP: if (seq_t == 5'(`IMK_GAP_TICKS - 1)) begin
               seq_t <= 5'h0;
               seq <= imk_pkg::SQ_TENS;
            end
            default: seq <= imk_pkg::SQ_TENS;
         endcase
      end
   end

   always_comb begin
      unique case (seq)
         imk_pkg::SQ_TENS: code_lamp = (seq_t < 5'(`IMK_LONG_ON));
         imk_pkg::SQ_UNITS: code_lamp = (seq_t < 5'(`IMK_SHORT_ON));
         default: code_lamp = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   logic next_lamp;
   always_comb begin
      unique case (state)
         imk_pkg::ST_MREG: next_lamp = 1'b1;
         imk_pkg::ST_STBY: next_lamp = (ph == 4'h0);
         imk_pkg::ST_FAULT: next_lamp = code_lamp;
         imk_pkg::ST_REG1, imk_pkg::ST_REG1OFF, imk_pkg::ST_REG2W:
            next_lamp = ph[0];
         default: next_lamp = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         LAMP <= 1'b0;
         ENGINE_EN <= 1'b0;
         ARMED <= 1'b1;
         STANDBY <= 1'b0;
         REG_MODE <= 1'b0;
         FAULT_VALID <= 1'b0;
         FAULT_CODE <= `IMK_FAULT_NONE;
      end else begin
         LAMP <= next_lamp;
         // the master key may also run the engine once it is known
         ENGINE_EN <= (state == imk_pkg::ST_RUN || state == imk_pkg::ST_MREG
                       || state == imk_pkg::ST_MON || state == imk_pkg::ST_REG1);
         ARMED <= (state == imk_pkg::ST_ARMED || state == imk_pkg::ST_STBY
                   || state == imk_pkg::ST_QUIET);
         STANDBY <= (state == imk_pkg::ST_STBY);
         REG_MODE <= (state == imk_pkg::ST_REG1 || state == imk_pkg::ST_REG1OFF
                      || state == imk_pkg::ST_REG2W);
         FAULT_VALID <= (state == imk_pkg::ST_FAULT);
         FAULT_CODE <= (state == imk_pkg::ST_FAULT) ? `IMK_FAULT_UNREG : `IMK_FAULT_NONE;
      end
   end
endmodule : imk_core

// [include/imk_map.svh]
// constants of the immobilizer key registration block
`ifndef IMK_MAP_SVH
`define IMK_MAP_SVH
// device clock rate
`define IMK_CLK_HZ 25000000
// flash ticks per second
`define IMK_FAST_PER_SEC 8
// lamp time after master key registration, seconds
`define IMK_REG_LAMP_S 1
// delay from switch-off to standby flashing, seconds
`define IMK_STBY_DLY_S 30
// longest standby flashing, hours
`define IMK_STBY_MAX_H 24
// seconds per hour
`define IMK_SEC_PER_H 3600
// window for each step of the entry sequence, seconds
`define IMK_SEQ_WIN_S 5
// fault code for an unregistered key (decimal 52)
`define IMK_FAULT_UNREG 8'h34
// fault code that means no fault
`define IMK_FAULT_NONE 8'h00
// key code width
`define IMK_CODE_W 32
// number of standard key slots
`define IMK_STD_KEYS 2
// standby blink period in flash ticks
`define IMK_STBY_PER 16
// code blink: long blink ticks on / period, short blink ticks on / period, gap
`define IMK_LONG_ON 4
`define IMK_LONG_PER 8
`define IMK_SHORT_ON 2
`define IMK_SHORT_PER 4
`define IMK_GAP_TICKS 16
`endif

// [include/imk_pkg.sv]
// types of the immobilizer key registration block
package imk_pkg;
   typedef enum logic [3:0] {
      ST_ARMED = 4'h0,   // off, armed, waiting for standby delay
      ST_STBY = 4'h1,    // off, standby flashing
      ST_QUIET = 4'h2,   // off, armed, flashing expired
      ST_MREG = 4'h3,    // master key just registered, lamp on
      ST_RUN = 4'h4,     // on with a registered key
      ST_FAULT = 4'h5,   // on with an unregistered key
      ST_MON = 4'h6,     // master on during standby
      ST_MOFF = 4'h7,    // master off, waiting for removal
      ST_MWAIT = 4'h8,   // master removed, waiting for first key
      ST_REG1 = 4'h9,    // first key registered, rapid flash
      ST_REG1OFF = 4'ha, // first key off, waiting for second key
      ST_REG2W = 4'hb    // second key inserted, waiting for switch-on
   } imk_state_t;
   typedef enum logic [1:0] {
      SQ_TENS = 2'h0,
      SQ_UNITS = 2'h1,
      SQ_GAP = 2'h2
   } imk_seq_t;
endpackage : imk_pkg

// [include/imk_tick_if.sv]
// timebase signals between the control logic and its tick divider
`timescale 1ns/1ns
interface imk_tick_if;
   logic restart;
   logic tick_fast;
   logic tick_sec;
   modport ctrl (output restart, input tick_fast, input tick_sec);
   modport gen (input restart, output tick_fast, output tick_sec);
endinterface : imk_tick_if

// [hw/imk_tick.sv]
// tick divider: flash-rate and one-second enable pulses, restartable
`timescale 1ns/1ns
`include "imk_map.svh"
module imk_tick #(
   parameter int SEC_CYCLES = `IMK_CLK_HZ
) (
   input wire logic clk,
   input wire logic arst_n,
   imk_tick_if.gen tk
);
   localparam int FAST_CYC = SEC_CYCLES / `IMK_FAST_PER_SEC;
   localparam logic [31:0] FAST_LAST = 32'(FAST_CYC - 1);
   localparam logic [2:0] SUB_LAST = 3'(`IMK_FAST_PER_SEC - 1);

   initial begin
      if (SEC_CYCLES < `IMK_FAST_PER_SEC || SEC_CYCLES % `IMK_FAST_PER_SEC != 0)
         $error("imk_tick: SEC_CYCLES must be a multiple of the flash rate");
   end

   logic [31:0] pre;
   logic [2:0] sub;
   logic wrap;
   assign wrap = (pre == FAST_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // prescaler; a restart realigns so the next second is a full second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre <= 32'h0;
         sub <= 3'h0;
      end else if (tk.restart) begin
         pre <= 32'h0;
         sub <= 3'h0;
      end else if (wrap) begin
         pre <= 32'h0;
         sub <= sub + 3'h1;
      end else begin
         pre <= pre + 32'h1;
      end
   end

   // pulses are combinational from the counters, one cycle wide; restart is
   // left out because it is decoded from a next state that reads these ticks
   assign tk.tick_fast = wrap;
   assign tk.tick_sec = wrap && (sub == SUB_LAST);
endmodule : imk_tick

// [dv/imk_core_sva.sv]
// checker of the immobilizer key registration outputs
`timescale 1ns/1ns
`include "imk_map.svh"
module imk_core_chk #(
   parameter int CODE_W = 32,
   parameter int SEC_CYCLES = 64,
   parameter int STBY_MAX_S = 3
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SW_ON,
   input wire logic KEY_IN,
   input wire logic [CODE_W-1:0] KEY_CODE,
   input wire logic LAMP,
   input wire logic ENGINE_EN,
   input wire logic ARMED,
   input wire logic STANDBY,
   input wire logic REG_MODE,
   input wire logic FAULT_VALID,
   input wire logic [7:0] FAULT_CODE
);
   localparam int TICK = SEC_CYCLES / 8;
   localparam int STBY_LIM = STBY_MAX_S * SEC_CYCLES + 2;
   localparam int WIN_LIM = 5 * SEC_CYCLES + 8;
   int stby_cnt;
   int lit_cnt;
   int flat_cnt;
   int idle_cnt;
   logic lamp_q;
   logic sw_q;
   logic key_q;
   ////////////////////////////////////////////////////////////////
   // run-length counters: spans this long cannot be unrolled as repetitions
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stby_cnt <= 0;
         lit_cnt <= 0;
         flat_cnt <= 0;
         idle_cnt <= 0;
         lamp_q <= 1'b0;
         sw_q <= 1'b0;
         key_q <= 1'b0;
      end else begin
         stby_cnt <= STANDBY ? stby_cnt + 1 : 0;
         lit_cnt <= (STANDBY && LAMP) ? lit_cnt + 1 : 0;
         // a switch-off or key insertion restarts the flash phase, so the run starts over
         flat_cnt <= (REG_MODE && LAMP == lamp_q && SW_ON == sw_q && KEY_IN == key_q) ? flat_cnt + 1 : 0;
         idle_cnt <= (REG_MODE && !SW_ON && !KEY_IN) ? idle_cnt + 1 : 0;
         lamp_q <= LAMP;
         sw_q <= SW_ON;
         key_q <= KEY_IN;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   sequence sw_off_s;
      $fell(SW_ON);
   endsequence
   sequence reg_exit_s;
      $fell(REG_MODE);
   endsequence
   fault_code_a: assert property (FAULT_VALID |-> FAULT_CODE == `IMK_FAULT_UNREG)
      else $error("fault code wrong while fault shown");
   no_fault_code_a: assert property (!FAULT_VALID |-> FAULT_CODE == `IMK_FAULT_NONE)
      else $error("fault code shown without fault");
   fault_no_start_a: assert property (FAULT_VALID |-> !ENGINE_EN)
      else $error("engine enabled with unregistered key");
   off_no_start_a: assert property (sw_off_s |-> ##4 !ENGINE_EN)
      else $error("engine still enabled after switch-off");
   standby_armed_a: assert property (STANDBY |-> ARMED && !ENGINE_EN)
      else $error("standby without arming");
   standby_len_a: assert property (STANDBY |-> stby_cnt < STBY_LIM)
      else $error("standby flashing too long");
   standby_blink_a: assert property ((STANDBY && LAMP) |-> lit_cnt < TICK + 1)
      else $error("standby blink too long");
   rapid_flash_a: assert property (REG_MODE |-> flat_cnt < TICK + 6)
      else $error("lamp not flashing rapidly in registration");
   reg_window_a: assert property (REG_MODE |-> idle_cnt < WIN_LIM)
      else $error("registration outlived second key window");
   reg_exit_dark_a: assert property (reg_exit_s |-> ##[0:1] !LAMP)
      else $error("lamp lit after registration ended");
endmodule : imk_core_chk

bind imk_core imk_core_chk #(.CODE_W(CODE_W), .SEC_CYCLES(SEC_CYCLES), .STBY_MAX_S(STBY_MAX_S)) chk_u (
   .CLK(CLK), .ARST_N(ARST_N), .SW_ON(SW_ON), .KEY_IN(KEY_IN), .KEY_CODE(KEY_CODE), .LAMP(LAMP),
   .ENGINE_EN(ENGINE_EN), .ARMED(ARMED), .STANDBY(STANDBY), .REG_MODE(REG_MODE),
   .FAULT_VALID(FAULT_VALID), .FAULT_CODE(FAULT_CODE));

// [dv/imk_key_sim.sv]
// ignition switch and transponder key model
`timescale 1ns/1ns
module imk_key_sim #(
   parameter int CODE_W = 32
) (
   input wire logic clk,
   output logic sw_on,
   output logic key_in,
   output logic [CODE_W-1:0] key_code
);
   initial begin
      sw_on = 1'b0;
      key_in = 1'b0;
      key_code = '0;
   end
   // code settles well before switch-on, since the pin sampler lags
   task put(input logic [CODE_W-1:0] c);
      @(posedge clk);
      key_code <= c;
      key_in <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask : put
   // returns right after the edge so the caller can time the answer
   task turn(input logic v);
      @(posedge clk);
      sw_on <= v;
      #1;
   endtask : turn
   // an empty reader shows no stale code, so it is inverted
   task pull;
      repeat (6) @(posedge clk);
      key_in <= 1'b0;
      key_code <= ~key_code;
      @(posedge clk);
      #1;
   endtask : pull
endmodule : imk_key_sim

// [dv/imk_core_tb_top.sv]
// self-checking testbench of the immobilizer key registration block
`timescale 1ns/1ns
module imk_core_tb_top;
   localparam int SC = 64;
   localparam int CW = 32;
   localparam int SMAX = 3;
   localparam logic [31:0] M = 32'h1a2b3c4d;
   localparam logic [31:0] A = 32'h000a11ce;
   localparam logic [31:0] B = 32'h000b0b0b;
   localparam logic [31:0] X = 32'hdeadbeef;
   localparam int LMP = 0, ENG = 1, ARM = 2, STB = 3, REG = 4, FLT = 5;
   logic CLK;
   logic ARST_N;
   wire SW_ON;
   wire KEY_IN;
   wire [31:0] KEY_CODE;
   logic LAMP, ENGINE_EN, ARMED, STANDBY, REG_MODE, FAULT_VALID;
   logic [7:0] FAULT_CODE;
   int err_total;
   int n_checks;
   wire [5:0] st = {FAULT_VALID, REG_MODE, STANDBY, ARMED, ENGINE_EN, LAMP};
   imk_core #(.CODE_W(CW), .SEC_CYCLES(SC), .STBY_MAX_S(SMAX)) dut_u (.CLK(CLK), .ARST_N(ARST_N),
      .SW_ON(SW_ON), .KEY_IN(KEY_IN), .KEY_CODE(KEY_CODE), .LAMP(LAMP), .ENGINE_EN(ENGINE_EN),
      .ARMED(ARMED), .STANDBY(STANDBY), .REG_MODE(REG_MODE), .FAULT_VALID(FAULT_VALID),
      .FAULT_CODE(FAULT_CODE));
   imk_key_sim #(.CODE_W(CW)) key_u (.clk(CLK), .sw_on(SW_ON), .key_in(KEY_IN), .key_code(KEY_CODE));
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // counts edges until a status bit reaches v; running out means a hang
   task automatic cnt_to(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (st[k] !== v && n < lim) begin
         @(posedge CLK);
         #1;
         n++;
      end
      if (st[k] !== v) begin
         err_total++;
         final_report();
      end
   endtask : cnt_to
   task automatic await(input int k, input logic v, input int lim);
      int n;
      cnt_to(k, v, lim, n);
   endtask : await
   // master on, off and removed in standby, then a key switched on
   task enter(input logic [31:0] c);
      key_u.put(M);
      key_u.turn(1'b1);
      await(ENG, 1'b1, 20);
      key_u.turn(1'b0);
      key_u.pull();
      key_u.put(c);
      key_u.turn(1'b1);
      await(REG, 1'b1, 20);
   endtask : enter
   ////////////////////////////////////////////////////////////////
   task sc_master;
      int n;
      chk(32'(st), 32'h04);
      key_u.put(M);
      key_u.turn(1'b1);
      await(LMP, 1'b1, 20);
      chk(32'(ENGINE_EN), 32'h1);
      cnt_to(LMP, 1'b0, 4 * SC, n);
      chk(n, SC);
   endtask : sc_master
   task sc_standby;
      int n;
      key_u.turn(1'b0);
      await(ARM, 1'b1, 20);
      chk(32'(ENGINE_EN), 32'h0);
      cnt_to(STB, 1'b1, 31 * SC, n);
      chk(n, 30 * SC);
      cnt_to(STB, 1'b0, 4 * SC, n);
      chk(n, SMAX * SC);
      chk(32'({ARMED, LAMP}), 32'h2);
      key_u.pull();
   endtask : sc_standby
   task sc_fault;
      int r;
      logic p;
      key_u.put(X);
      key_u.turn(1'b1);
      await(FLT, 1'b1, 20);
      chk(32'(FAULT_CODE), 32'h34);
      chk(32'(ENGINE_EN), 32'h0);
      await(LMP, 1'b1, 4 * SC);
      // one full blink period of 64 flash ticks holds 5 long and 2 short blinks
      r = 0;
      p = LAMP;
      repeat (8 * SC) begin
         @(posedge CLK);
         #1;
         if (LAMP === 1'b1 && p === 1'b0) r++;
         p = LAMP;
      end
      chk(r, 7);
      key_u.turn(1'b0);
      key_u.pull();
   endtask : sc_fault
   task sc_reg2;
      int t;
      logic p;
      await(STB, 1'b1, 31 * SC);
      enter(A);
      t = 0;
      p = LAMP;
      repeat (SC) begin
         @(posedge CLK);
         #1;
         if (LAMP !== p) t++;
         p = LAMP;
      end
      chk(t, 8);
      key_u.turn(1'b0);
      key_u.pull();
      key_u.put(B);
      key_u.turn(1'b1);
      await(REG, 1'b0, 20);
      chk(32'({LAMP, ENGINE_EN}), 32'h1);
      key_u.turn(1'b0);
      key_u.pull();
      key_u.put(A);
      key_u.turn(1'b1);
      await(ENG, 1'b1, 20);
      chk(32'(FAULT_VALID), 32'h0);
      key_u.turn(1'b0);
      key_u.pull();
   endtask : sc_reg2
   task sc_void;
      int n;
      await(STB, 1'b1, 31 * SC);
      enter(B);
      key_u.turn(1'b0);
      key_u.pull();
      cnt_to(REG, 1'b0, 6 * SC, n);
      chk(32'(n >= 5 * SC - 8 && n <= 5 * SC + 8), 32'h1);
      key_u.put(A);
      key_u.turn(1'b1);
      await(FLT, 1'b1, 20);
      key_u.turn(1'b0);
      key_u.pull();
      key_u.put(B);
      key_u.turn(1'b1);
      await(ENG, 1'b1, 20);
      chk(32'(FAULT_VALID), 32'h0);
   endtask : sc_void
   ////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      n_checks = 0;
      ARST_N = 1'b0;
      repeat (8) @(posedge CLK);
      ARST_N <= 1'b1;
      @(posedge CLK);
      #1;
      sc_master();
      sc_standby();
      sc_fault();
      sc_reg2();
      sc_void();
      final_report();
   end
   // cut a hang short well inside the cycle budget
   initial begin
      repeat (100000) @(posedge CLK);
      err_total++;
      final_report();
   end
endmodule : imk_core_tb_top
